// ### design/boot_cmd_params.svh
// Constants for the boot-loader command handler
`ifndef BOOT_CMD_PARAMS_SVH
`define BOOT_CMD_PARAMS_SVH

// ****************************************
// Command codes
// ****************************************
`define CMD_UNLOCK 8'hE0
`define CMD_CAPABILITY 8'hE4
`define CMD_STATUS 8'hE5
`define CMD_CONTROL 8'hE6
`define CMD_DATA 8'hE7
`define CMD_PRODUCT 8'hE8

// ****************************************
// Control actions and keys
// ****************************************
`define ACT_ENTER 8'h01
`define ACT_ERASE 8'h02
`define ACT_DONE 8'h03
`define ACT_EXIT 8'h04
`define UNLOCK_KEY 32'h55504744
`define SEL_BOOST 8'h70
`define SEL_SECONDARY 8'h73
`define SEL_INTERFACE 8'h69

// ****************************************
// Write frame byte positions (address byte is 0)
// ****************************************
`define IDX_CMD 9'h001
`define IDX_SEL 9'h002
`define IDX_SEQ_HI 9'h004
`define IDX_COUNT 9'h005
`define IDX_DATA 9'h006
`define IDX_CTRL_PEC 9'h004
`define IDX_KEY_PEC 9'h007

// ****************************************
// Read answer lengths and positions
// ****************************************
`define CAP_COUNT 8'h07
`define SEQ_COUNT 8'h03
`define PROD_COUNT 8'h0B
`define K_CAP_PEC 4'h8
`define K_STAT_PEC 4'h1
`define K_SEQ_PEC 4'h4
`define K_PROD_PEC 4'hC

// ****************************************
// Checks
// ****************************************
`define CRC8_POLY 8'h07
`define CRC16_POLY 16'h1021
`define CRC16_INIT 16'hFFFF

// ****************************************
// APB map and reset values
// ****************************************
`define OFS_CTRL 8'h00
`define OFS_CAP 8'h04
`define OFS_DUR 8'h08
`define OFS_STAT 8'h0C
`define CTRL_MAIN_BIT 8
`define SADDR_RST 7'h58
`define MAX_LEN_RST 8'h20
`define ERASE_DUR_RST 16'h03E8
`define WRITE_DUR_RST 16'h01F4

`endif

// ### design/boot_cmd_pkg.sv
// Types for the boot-loader command handler
package boot_cmd_pkg;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_ACK, ST_ACKD, ST_TX, ST_TXACK, ST_TXHOLD
   } link_st_type;

   typedef struct packed {
      link_st_type st;
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic scl_q;
      logic sda_q;
      logic in_frame;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] txb;
      logic [8:0] idx;
      logic rd;
      logic [3:0] k;
      logic [7:0] cmd;
      logic [7:0] sel;
      logic [7:0] n;
      logic [31:0] arg;
      logic [15:0] seq_in;
      logic [7:0] crc8;
      logic [15:0] w_crc;
      logic [7:0] w_h0;
      logic [7:0] w_h1;
      logic [15:0] w_cnt;
      logic [15:0] c_crc;
      logic [7:0] c_h0;
      logic [7:0] c_h1;
      logic [15:0] c_cnt;
      logic [15:0] seq;
      logic unlocked;
      logic in_boot;
      logic erased;
      logic app_ok;
      logic error;
      logic app_run;
      logic main_out;
      logic sda_oe;
      logic sda_low;
      logic [6:0] saddr;
      logic [7:0] max_len;
      logic [15:0] erase_duration;
      logic [15:0] packet_write_duration;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } state_type;

endpackage

// ### design/boot_cmd_handler.sv
// Boot-loader command handler: SMBus slave with PEC and APB configuration
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
`include "boot_cmd_params.svh"

// Operation
// - Capability read answers count 7, max length, durations, image CRC, PEC
// - Erase duration in ms, packet write duration in us, 16-bit little endian
// - Status read answers one status byte followed by PEC
// - Status: 0 available, 0x08 bad address, 0x40 downstream, 0x80 in boot
// - Control action: 1 enter, 2 erase, 3 done, 4 exit
// - Selector ignored for enter and exit actions
// - Entering the upgrade switches the main output off
// - After erase the status reads 0x81
// - Data write: selector, 16-bit sequence, count, data, PEC; first is zero
// - Accepted packet increments sequence; read returns 3, sequence, status, PEC
// - Done computes CRC-16 over image and compares with its last two bytes
// - After done, status reads 0x80 when the checksum is valid
// - Exit hands control to the application; status then reads 0x00
// - Any reprogramming error keeps the device in the boot loader
// - Product code read answers count 11, eleven bytes, PEC
// - Upgrade commands stay locked until the four-character key arrives
// - Selector letters p, s, i name boost, secondary, interface processors
module boot_cmd_handler #(
   parameter logic [87:0] PRODUCT_CODE = 88'h30_31_32_33_34_35_36_37_38_39_41, // Arbitrary value
   parameter int MAX_LEN_RESET = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic main_out_en,
   output logic app_run
);
   import boot_cmd_pkg::*;

   if (MAX_LEN_RESET < 1 || MAX_LEN_RESET > 255) begin : g_chk
      $error("MAX_LEN_RESET must lie in 1..255");
   end

   // ****************************************
   // Arithmetic
   // ****************************************
   function automatic logic [7:0] crc8_f(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ((x << 1) ^ `CRC8_POLY) : (x << 1);
      end
      return x;
   endfunction

   function automatic logic [15:0] crc16_f(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] x;
      x = c ^ {d, 8'h00};
      for (int i = 0; i < 8; i++) begin
         x = x[15] ? ((x << 1) ^ `CRC16_POLY) : (x << 1);
      end
      return x;
   endfunction

   function automatic logic [7:0] resp_f(input state_type s, input logic [3:0] k, input logic [7:0] st);
      logic [7:0] b;
      b = 8'hFF;
      case (s.cmd)
         `CMD_CAPABILITY: begin
            case (k)
               4'h0: b = `CAP_COUNT;
               4'h1: b = s.max_len;
               4'h2: b = s.erase_duration[7:0];
               4'h3: b = s.erase_duration[15:8];
               4'h4: b = s.packet_write_duration[7:0];
               4'h5: b = s.packet_write_duration[15:8];
               4'h6: b = s.c_crc[7:0];
               4'h7: b = s.c_crc[15:8];
               `K_CAP_PEC: b = s.crc8;
               default: b = 8'hFF;
            endcase
         end
         `CMD_STATUS: begin
            b = (k == 4'h0) ? st : ((k == `K_STAT_PEC) ? s.crc8 : 8'hFF);
         end
         `CMD_DATA: begin
            case (k)
               4'h0: b = `SEQ_COUNT;
               4'h1: b = s.seq[7:0];
               4'h2: b = s.seq[15:8];
               4'h3: b = st;
               `K_SEQ_PEC: b = s.crc8;
               default: b = 8'hFF;
            endcase
         end
         `CMD_PRODUCT: begin
            if (k == 4'h0) begin
               b = `PROD_COUNT;
            end else if (k < `K_PROD_PEC) begin
               b = PRODUCT_CODE[8 * (11 - int'(k)) +: 8];
            end else if (k == `K_PROD_PEC) begin
               b = s.crc8;
            end
         end
         default: b = 8'hFF;
      endcase
      return b;
   endfunction

   state_type r;
   state_type n;
   logic [7:0] status_byte;
   logic ev_enter;
   logic ev_erase;
   logic ev_done_ok;
   logic ev_exit;
   logic ev_commit;
   logic ev_load0;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic scl;
      logic sda;
      logic rise;
      logic fall;
      logic [7:0] b;
      logic pec_ok;
      logic sel_ok;
      logic bad_addr;
      scl = r.scl_s[1];
      sda = r.sda_s[1];
      rise = scl & ~r.scl_q;
      fall = ~scl & r.scl_q;
      b = {r.shreg[6:0], sda};
      pec_ok = (crc8_f(r.crc8, b) == 8'h00);
      sel_ok = (r.sel == `SEL_BOOST) || (r.sel == `SEL_SECONDARY) || (r.sel == `SEL_INTERFACE);
      bad_addr = (paddr[1:0] != 2'b00) || (paddr > `OFS_STAT);
      status_byte = {r.in_boot, r.sel == `SEL_INTERFACE, 2'b00, ~sel_ok, 2'b00, r.erased};
      n = r;
      ev_enter = 1'b0;
      ev_erase = 1'b0;
      ev_done_ok = 1'b0;
      ev_exit = 1'b0;
      ev_commit = 1'b0;
      ev_load0 = 1'b0;
      n.scl_s = {r.scl_s[0], scl_in};
      n.sda_s = {r.sda_s[0], sda_in};
      n.scl_q = scl;
      n.sda_q = sda;
      if (scl && r.scl_q && !sda && r.sda_q) begin
         // Repeated start keeps the running PEC across the direction change
         n.st = ST_RX;
         n.bitcnt = 4'h0;
         n.idx = 9'h000;
         n.sda_oe = 1'b0;
         n.in_frame = 1'b1;
         if (!r.in_frame) begin
            n.crc8 = 8'h00;
         end
      end else if (scl && r.scl_q && sda && !r.sda_q) begin
         n.st = ST_IDLE;
         n.in_frame = 1'b0;
         n.sda_oe = 1'b0;
      end else begin
         case (r.st)
            ST_RX: begin
               if (rise) begin
                  n.shreg = b;
                  n.bitcnt = r.bitcnt + 4'h1;
                  if (r.bitcnt == 4'h7) begin
                     n.crc8 = crc8_f(r.crc8, b);
                     n.idx = r.idx + 9'h001;
                     n.arg = {r.arg[23:0], b};
                     n.st = ST_ACK;
                     if (r.idx == 9'h000) begin
                        n.rd = b[0];
                        n.k = 4'h0;
                        if (b[7:1] != r.saddr) begin
                           n.st = ST_IDLE;
                           n.in_frame = 1'b0;
                        end
                     end else if (r.idx == `IDX_CMD) begin
                        n.cmd = b;
                     end else if (r.idx == `IDX_SEL && r.cmd != `CMD_UNLOCK) begin
                        n.sel = b;
                     end else if (r.cmd == `CMD_UNLOCK) begin
                        if (r.idx == `IDX_KEY_PEC && pec_ok && r.arg == `UNLOCK_KEY) begin
                           n.unlocked = 1'b1;
                        end
                     end else if (r.cmd == `CMD_CONTROL) begin
                        if (r.idx == `IDX_CTRL_PEC && pec_ok && r.unlocked) begin
                           case (r.arg[7:0])
                              `ACT_ENTER: begin
                                 ev_enter = 1'b1;
                                 n.in_boot = 1'b1;
                                 n.app_run = 1'b0;
                                 n.main_out = 1'b0;
                              end
                              `ACT_ERASE: begin
                                 if (r.in_boot && sel_ok) begin
                                    ev_erase = 1'b1;
                                    n.erased = 1'b1;
                                    n.app_ok = 1'b0;
                                    n.error = 1'b0;
                                    n.seq = 16'h0000;
                                    n.c_crc = `CRC16_INIT;
                                    n.c_cnt = 16'h0000;
                                    n.c_h0 = 8'h00;
                                    n.c_h1 = 8'h00;
                                 end
                              end
                              `ACT_DONE: begin
                                 if (r.c_cnt >= 16'h0002 && r.c_crc == {r.c_h1, r.c_h0} && !r.error) begin
                                    ev_done_ok = 1'b1;
                                    n.erased = 1'b0;
                                    n.app_ok = 1'b1;
                                 end else begin
                                    n.error = 1'b1;
                                 end
                              end
                              `ACT_EXIT: begin
                                 if (r.app_ok && !r.error) begin
                                    ev_exit = 1'b1;
                                    n.in_boot = 1'b0;
                                    n.app_run = 1'b1;
                                 end
                              end
                              default: n.error = r.error;
                           endcase
                        end
                     end else if (r.cmd == `CMD_DATA) begin
                        if (r.idx == `IDX_SEQ_HI) begin
                           n.seq_in = {b, r.arg[7:0]};
                        end else if (r.idx == `IDX_COUNT) begin
                           n.n = b;
                           n.w_crc = r.c_crc;
                           n.w_h0 = r.c_h0;
                           n.w_h1 = r.c_h1;
                           n.w_cnt = r.c_cnt;
                        end else if (r.idx < `IDX_DATA + {1'b0, r.n}) begin
                           // Trailing two bytes are held back: they are the image checksum
                           if (r.w_cnt >= 16'h0002) begin
                              n.w_crc = crc16_f(r.w_crc, r.w_h1);
                           end
                           n.w_h1 = r.w_h0;
                           n.w_h0 = b;
                           n.w_cnt = r.w_cnt + 16'h0001;
                        end else if (r.idx == `IDX_DATA + {1'b0, r.n} && pec_ok) begin
                           if (r.unlocked && r.in_boot && r.erased && r.seq_in == r.seq
                               && r.n != 8'h00 && r.n <= r.max_len) begin
                              ev_commit = 1'b1;
                              n.c_crc = r.w_crc;
                              n.c_h0 = r.w_h0;
                              n.c_h1 = r.w_h1;
                              n.c_cnt = r.w_cnt;
                              n.seq = r.seq + 16'h0001;
                           end else begin
                              n.error = 1'b1;
                           end
                        end
                     end
                  end
               end
            end
            ST_ACK: begin
               if (fall) begin
                  n.sda_oe = 1'b1;
                  n.st = ST_ACKD;
               end
            end
            ST_ACKD: begin
               if (fall) begin
                  n.bitcnt = 4'h0;
                  if (r.rd) begin
                     ev_load0 = 1'b1;
                     n.txb = resp_f(r, 4'h0, status_byte);
                     n.sda_oe = ~n.txb[7];
                     n.st = ST_TX;
                  end else begin
                     n.sda_oe = 1'b0;
                     n.st = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (rise) begin
                  n.bitcnt = r.bitcnt + 4'h1;
               end else if (fall) begin
                  if (r.bitcnt == 4'h8) begin
                     n.sda_oe = 1'b0;
                     n.crc8 = crc8_f(r.crc8, r.txb);
                     n.st = ST_TXACK;
                  end else begin
                     n.sda_oe = ~r.txb[3'(4'h7 - r.bitcnt)];
                  end
               end
            end
            ST_TXACK: begin
               if (rise) begin
                  if (sda) begin
                     n.st = ST_IDLE;
                  end else begin
                     n.k = r.k + 4'h1;
                     n.txb = resp_f(r, r.k + 4'h1, status_byte);
                     n.st = ST_TXHOLD;
                  end
               end
            end
            ST_TXHOLD: begin
               if (fall) begin
                  n.sda_oe = ~r.txb[7];
                  n.bitcnt = 4'h0;
                  n.st = ST_TX;
               end
            end
            default: n.st = ST_IDLE;
         endcase
      end

      // APB slave: answer in the second access cycle
      n.pready = psel & penable & ~r.pready;
      n.pslverr = psel & penable & ~r.pready & bad_addr;
      if (psel && !penable) begin
         case (paddr)
            `OFS_CTRL: n.prdata = {23'h000000, r.main_out, 1'b0, r.saddr};
            `OFS_CAP: n.prdata = {24'h000000, r.max_len};
            `OFS_DUR: n.prdata = {r.packet_write_duration, r.erase_duration};
            `OFS_STAT: n.prdata = {5'h00, r.error, r.app_run, r.unlocked, r.seq, status_byte};
            default: n.prdata = 32'h00000000;
         endcase
      end
      if (psel && penable && r.pready && pwrite) begin
         case (paddr)
            `OFS_CTRL: begin
               n.saddr = pwdata[6:0];
               // Boot loader keeps the main output off while it owns the processor
               n.main_out = pwdata[`CTRL_MAIN_BIT] & ~r.in_boot & ~ev_enter;
            end
            `OFS_CAP: n.max_len = pwdata[7:0];
            `OFS_DUR: begin
               n.erase_duration = pwdata[15:0];
               n.packet_write_duration = pwdata[31:16];
            end
            default: n.saddr = r.saddr;
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.scl_s <= 2'b11;
         r.sda_s <= 2'b11;
         r.scl_q <= 1'b1;
         r.sda_q <= 1'b1;
         r.c_crc <= `CRC16_INIT;
         r.w_crc <= `CRC16_INIT;
         r.app_run <= 1'b1;
         r.saddr <= `SADDR_RST;
         r.max_len <= 8'(MAX_LEN_RESET);
         r.erase_duration <= `ERASE_DUR_RST;
         r.packet_write_duration <= `WRITE_DUR_RST;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign sda_out = r.sda_low;
   assign sda_oe = r.sda_oe;
   assign main_out_en = r.main_out;
   assign app_run = r.app_run;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_apb_access;
      psel && penable && !pready;
   endsequence

   property p_apb_ready;
      s_apb_access |=> pready ##1 !pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("APB answer not in second access cycle");

   property p_seq_step;
      $changed(r.seq) |-> (r.seq == $past(r.seq) + 16'h0001) || (r.seq == 16'h0000);
   endproperty
   a_seq_step: assert property (p_seq_step) else $error("Sequence jumped");

   property p_locked;
      !r.unlocked |=> $stable(r.seq) && $stable(r.in_boot);
   endproperty
   a_locked: assert property (p_locked) else $error("Upgrade state changed while locked");

   property p_enter_off;
      ev_enter |=> !main_out_en && r.in_boot ##1 !main_out_en;
   endproperty
   a_enter_off: assert property (p_enter_off) else $error("Main output on after enter");

   property p_erase;
      ev_erase |=> status_byte[7] && status_byte[0] && r.seq == 16'h0000;
   endproperty
   a_erase: assert property (p_erase) else $error("Status not erased after erase");

   property p_done;
      ev_done_ok |=> !r.erased && r.app_ok;
   endproperty
   a_done: assert property (p_done) else $error("Valid image not marked good");

   property p_exit_refused;
      r.error && r.in_boot |=> r.in_boot;
   endproperty
   a_exit_refused: assert property (p_exit_refused) else $error("Left boot loader with error");

   property p_exit;
      ev_exit |=> app_run && !r.in_boot;
   endproperty
   a_exit: assert property (p_exit) else $error("Application not started on exit");

   property p_cap_count;
      ev_load0 && r.cmd == `CMD_CAPABILITY |=> r.txb == `CAP_COUNT;
   endproperty
   a_cap_count: assert property (p_cap_count) else $error("Capability count wrong");

   property p_reserved;
      status_byte[5:4] == 2'b00 && status_byte[2:1] == 2'b00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("Reserved status bits set");

endmodule // boot_cmd_handler

// ### dv/smb_host.sv
// SMBus host master model for the boot-loader command handler
`timescale 1ns/10ps
// ***
// Bit and byte level host
// ***
module smb_host (
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // 200 ns bit period; clock stands high between frames
   task automatic bit_x(input logic b, output logic r);
      sda_low = !b;
      #50 scl = 1'b1;
      #50 r = sda;
      #50 scl = 1'b0;
      #50;
   endtask
   // Serves as start from idle and as repeated start after a byte
   task automatic start;
      sda_low = 1'b0;
      #50 scl = 1'b1;
      #50 sda_low = 1'b1;
      #50 scl = 1'b0;
      #50;
   endtask
   task automatic stop;
      sda_low = 1'b1;
      #50 scl = 1'b1;
      #50 sda_low = 1'b0;
      #100;
   endtask
   // Sending all ones releases the line so the device can answer
   task automatic byte_x(input logic [7:0] b, input logic ack_in, output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
      bit_x(ack_in, ack);
   endtask
endmodule // smb_host

// ### dv/tb.sv
// Self-checking bench for the boot-loader command handler
`timescale 1ns/10ps
`include "boot_cmd_params.svh"
module tb;
   import boot_cmd_pkg::*;
   localparam logic [87:0] PCODE = 88'h41_42_43_44_45_46_47_48_49_4A_4B; // Arbitrary value
   localparam int ML = 24;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, scl, sda_low, sda_oe, main_out_en, app_run, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] rx[16];
   logic [7:0] q[$];
   int n_errors, checks_done, cyc;
   wire sda = !(sda_oe || sda_low);
   boot_cmd_handler #(.PRODUCT_CODE(PCODE), .MAX_LEN_RESET(ML)) boot_cmd_handler_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .sda_out(),
      .sda_oe(sda_oe), .main_out_en(main_out_en), .app_run(app_run));
   smb_host smb_host_inst (.scl(scl), .sda_low(sda_low), .sda(sda));
   always #12.5 pclk = !pclk;
   // ***
   // Shared tasks
   // ***
   task automatic finish_test;
      if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ `CRC8_POLY : {x[6:0], 1'b0};
      return x;
   endfunction
   function automatic logic [15:0] crc16(input logic [15:0] d);
      logic [15:0] c;
      c = `CRC16_INIT;
      for (int i = 15; i >= 0; i--) c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ `CRC16_POLY : {c[14:0], 1'b0};
      return c;
   endfunction
   // Sends q after the address; nrd answer bytes plus PEC are read after a repeated start
   task automatic xfer(input int nrd, input logic bad);
      logic [7:0] p, r;
      logic a;
      p = 8'h00;
      q.push_front({`SADDR_RST, 1'b0});
      smb_host_inst.start();
      foreach (q[i]) begin
         p = crc8(p, q[i]);
         smb_host_inst.byte_x(q[i], 1'b1, r, a);
      end
      if (nrd == 0) smb_host_inst.byte_x(p ^ {7'h00, bad}, 1'b1, r, a);
      else begin
         smb_host_inst.start();
         p = crc8(p, {`SADDR_RST, 1'b1});
         smb_host_inst.byte_x({`SADDR_RST, 1'b1}, 1'b1, r, a);
         for (int i = 0; i <= nrd; i++) begin
            smb_host_inst.byte_x(8'hFF, i == nrd, rx[i], a);
            if (i < nrd) p = crc8(p, rx[i]);
         end
         check("pec", rx[nrd], p);
      end
      smb_host_inst.stop();
      q = {};
   endtask
   task automatic ctl(input logic [7:0] s, input logic [7:0] act);
      q = {`CMD_CONTROL, s, act};
      xfer(0, 1'b0);
   endtask
   task automatic stat(input logic [7:0] s, input logic [7:0] exp);
      q = {`CMD_STATUS, s};
      xfer(1, 1'b0);
      check("status", rx[0], exp);
   endtask
   task automatic pkt(input logic [15:0] sq, input logic bad);
      logic [15:0] c;
      c = crc16(16'h1122);
      q = {`CMD_DATA, `SEL_BOOST, sq[7:0], sq[15:8], 8'h04, 8'h11, 8'h22, c[15:8], c[7:0]};
      xfer(0, bad);
   endtask
   task automatic seqrd(input logic [15:0] sq, input logic [7:0] st);
      q = {`CMD_DATA, `SEL_BOOST};
      xfer(4, 1'b0);
      check("seq", {rx[0], rx[2], rx[1], rx[3]}, {`SEQ_COUNT, sq, st});
   endtask
   // ***
   // Scenarios
   // ***
   task automatic t_regs;
      apb(1'b0, `OFS_CAP, 32'h0);
      check("cap", rd[7:0], 8'(ML));
      apb(1'b0, `OFS_DUR, 32'h0);
      check("dur", rd, {`WRITE_DUR_RST, `ERASE_DUR_RST});
      apb(1'b0, 8'h10, 32'h0);
      check("slverr", er, 1'b1);
      check("unmapped", rd, 32'h0);
   endtask
   task automatic t_query;
      apb(1'b1, `OFS_DUR, 32'h0BB8_07D0);
      q = {`CMD_CAPABILITY, `SEL_BOOST};
      xfer(8, 1'b0);
      check("cap", {rx[0], rx[1]}, {`CAP_COUNT, 8'(ML)});
      check("durations", {rx[3], rx[2], rx[5], rx[4]}, 32'h07D0_0BB8);
      check("image_crc", {rx[7], rx[6]}, `CRC16_INIT);
      stat(`SEL_BOOST, 8'h00);
      stat(`SEL_INTERFACE, 8'h40);
      stat(8'h78, 8'h08);
      q = {`CMD_PRODUCT};
      xfer(12, 1'b0);
      check("prod", rx[0], `PROD_COUNT);
      for (int i = 0; i < 11; i++) check("code", rx[1 + i], PCODE[87 - 8 * i -: 8]);
   endtask
   task automatic t_enter;
      apb(1'b1, `OFS_CTRL, 32'h0000_0158);
      ctl(`SEL_BOOST, `ACT_ENTER);
      check("locked", {main_out_en, app_run}, 2'b11);
      q = {`CMD_UNLOCK, 8'h04, 8'h55, 8'h50, 8'h47, 8'h44};
      xfer(0, 1'b0);
      ctl(8'h00, `ACT_ENTER);
      check("enter", {main_out_en, app_run}, 2'b00);
      stat(`SEL_BOOST, 8'h80);
   endtask
   task automatic t_error;
      ctl(`SEL_BOOST, `ACT_ERASE);
      // Host pause after erase would go here; durations are only reported
      stat(`SEL_BOOST, 8'h81);
      pkt(16'h0005, 1'b0);
      ctl(8'h00, `ACT_EXIT);
      apb(1'b0, `OFS_STAT, 32'h0);
      check("refused", {app_run, rd[26]}, 2'b01);
   endtask
   task automatic t_program;
      ctl(`SEL_BOOST, `ACT_ERASE);
      pkt(16'h0000, 1'b0);
      seqrd(16'h0001, 8'h81);
      pkt(16'h0001, 1'b1);
      seqrd(16'h0001, 8'h81);
      ctl(`SEL_BOOST, `ACT_DONE);
      stat(`SEL_BOOST, 8'h80);
      ctl(8'h00, `ACT_EXIT);
      check("exit", app_run, 1'b1);
      stat(`SEL_BOOST, 8'h00);
   endtask
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      t_regs();
      t_query();
      t_enter();
      t_error();
      t_program();
      finish_test();
   end
endmodule // tb
